// ==== pscc_pkg.sv ====
// Constants and types shared by the passive serial configuration loader.
// Assumes a single system clock; all pin timing is expressed in its cycles.
`default_nettype none

package pscc_pkg;

  // Stream shape.
  localparam int             WORD_W       = 8;
  localparam int             BIT_CNT_W    = 3;
  localparam int             WORD_CNT_W   = 7;
  localparam int             FIFO_DEPTH   = 16;
  localparam logic [6:0]     STREAM_WORDS = 7'h40;
  localparam logic [2:0]     LAST_BIT     = 3'h7;

  // Initialisation cycle length in system clocks.
  localparam logic [3:0]     INIT_CYCLES  = 4'h8;

  // Reset values.
  localparam logic           ODRAIN_OFF   = 1'h1;
  localparam logic [7:0]     WORD_ZERO    = 8'h00;
  localparam logic [2:0]     BIT_ZERO     = 3'h0;
  localparam logic [6:0]     WCNT_ZERO    = 7'h00;
  localparam logic [3:0]     INIT_ZERO    = 4'h0;

  typedef enum logic [2:0]
  {
    PSCC_IDLE,
    PSCC_LOAD,
    PSCC_INIT,
    PSCC_USER,
    PSCC_ERROR
  } pscc_state_type;

endpackage

`default_nettype wire

// ==== pscc_sync.sv ====
// Two-stage synchroniser for pins that arrive from outside the clock domain.
// Assumes the inputs are quasi-static relative to clk_sys and do not glitch.
`timescale 1ns/1ps
`default_nettype none

module pscc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and control
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed
  {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } pscc_sync_state_type;

  pscc_sync_state_type r;
  pscc_sync_state_type next_r;

  // The first stage is read only by the second stage.
  always_comb
  begin
    next_r        = r;
    next_r.stage1 = async_in;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      r <= '0;
    else if (clk_en)
      r <= next_r;
  end

  assign sync_out = r.stage2;

endmodule

`default_nettype wire

// ==== pscc_fifo.sv ====
// Flip-flop FIFO with a registered output stage, valid and ready on both sides.
// Assumes the reader may stall indefinitely; in_ready drops when storage is full.
`timescale 1ns/1ps
`default_nettype none

module pscc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and control
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Write side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Read side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
    logic [WIDTH-1:0]            head;
    logic                        head_valid;
  } pscc_fifo_state_type;

  pscc_fifo_state_type r;
  pscc_fifo_state_type next_r;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  assign in_ready = (r.count != CNT_W'(DEPTH));

  // The head register keeps the read side straight from a flip-flop.
  always_comb
  begin
    logic push;
    logic pop;
    logic [CNT_W-1:0] cnt;
    push   = in_valid && in_ready;
    pop    = r.head_valid && out_ready;
    next_r = r;
    cnt    = r.count;
    if (push)
    begin
      next_r.mem[r.wr_ptr] = in_data;
      next_r.wr_ptr        = ptr_inc(r.wr_ptr);
      cnt                  = cnt + CNT_W'(1);
    end
    if (pop)
      next_r.head_valid = 1'b0;
    if ((!r.head_valid || pop) && (r.count != '0))
    begin
      next_r.head       = r.mem[r.rd_ptr];
      next_r.head_valid = 1'b1;
      next_r.rd_ptr     = ptr_inc(r.rd_ptr);
      cnt               = cnt - CNT_W'(1);
    end
    next_r.count = cnt;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      r <= '0;
    else if (clk_en)
      r <= next_r;
  end

  assign out_valid = r.head_valid;
  assign out_data  = r.head;

endmodule

`default_nettype wire

// ==== pscc_loader.sv ====
// Passive serial configuration loader: samples the host's serial stream,
// assembles bytes, checks the stream and drives the status pins.
// Assumes the host drives the configuration clock and data pins; the clock is
// oversampled by clk_sys, so it must be well below a quarter of clk_sys.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1 - Host presents one bit per config_clock rising edge; device samples it there.
// R2 - No limit on config_clock period; a halted clock simply pauses loading.
// R3 - Host drives config_clock and serial data to fixed levels after configuration.
// R4 - Serial data pin stays tri-stated in user mode unless the user drives it.
// R5 - After configuration the serial data pin serves as general user I/O.
// R6 - Device pulls config_complete_flag low before and during configuration.
// R7 - Flag released only after an error-free full stream, as initialization starts.
// R8 - After data and a high config_complete_flag, initialize then enter user mode.
// R9 - Outside low on config_complete_flag after initialization leaves user mode intact.
// R10 - Host watches config_complete_flag and init_complete_flag for errors and completion.
// R11 - Host restarts configuration when a full stream does not raise both flags.
// R12 - Configuration is accepted only while chip_enable_n is low.
// R13 - Outside party holds chip_enable_n low through configuration and user mode.
// R14 - chip_enable_n must be low for boundary-scan programming.
// R15 - Device drives open-drain chip_enable_out_n low once configuration completes.
// R16 - In a chain each chip_enable_out_n feeds the next chip_enable_n.
// R17 - Unused chip_enable_out_n may be released as user I/O after configuration.
// R18 - init_complete_flag rises only after initialization ends and user mode begins.
module pscc_loader
(
  // Clock and control
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_en,
  // Configuration pins from the host
  input  wire logic                       config_clock,
  input  wire logic                       chip_enable_n,
  // Serial data pin, two-way after configuration
  input  wire logic                       config_serial_in,
  output logic                            config_serial_out,
  output logic                            config_serial_oe_n,
  // Open-drain completion flag
  input  wire logic                       config_complete_in,
  output logic                            config_complete_out,
  output logic                            config_complete_oe_n,
  // Open-drain chain enable to the next device
  output logic                            chip_enable_out_n,
  output logic                            chip_enable_out_oe_n,
  // Status
  output logic                            init_complete_flag,
  output logic                            load_error,
  // User-mode pin control
  input  wire logic                       user_serial_out,
  input  wire logic                       user_serial_oe_n,
  input  wire logic                       user_ceo_release,
  output logic                            user_serial_in,
  // Configuration words towards the array
  output logic                            cfg_valid,
  output logic [pscc_pkg::WORD_W-1:0]     cfg_data,
  input  wire logic                       cfg_ready
);

  typedef struct packed
  {
    pscc_pkg::pscc_state_type              state;
    logic                                  ck_prev;
    logic [pscc_pkg::BIT_CNT_W-1:0]        bit_cnt;
    logic [pscc_pkg::WORD_W-1:0]           shift;
    logic [pscc_pkg::WORD_CNT_W-1:0]       word_cnt;
    logic [pscc_pkg::WORD_W-1:0]           check;
    logic                                  push_valid;
    logic [pscc_pkg::WORD_W-1:0]           push_data;
    logic [3:0]                            init_cnt;
    logic                                  ccf_oe_n;
    logic                                  ceo_out;
    logic                                  ceo_oe_n;
    logic                                  init_done;
    logic                                  err;
    logic                                  ser_out;
    logic                                  ser_oe_n;
    logic                                  ser_in;
  } pscc_loader_state_type;

  localparam pscc_loader_state_type RESET_STATE = '{
    state:      pscc_pkg::PSCC_IDLE,
    ck_prev:    1'b0,
    bit_cnt:    pscc_pkg::BIT_ZERO,
    shift:      pscc_pkg::WORD_ZERO,
    word_cnt:   pscc_pkg::WCNT_ZERO,
    check:      pscc_pkg::WORD_ZERO,
    push_valid: 1'b0,
    push_data:  pscc_pkg::WORD_ZERO,
    init_cnt:   pscc_pkg::INIT_ZERO,
    ccf_oe_n:   1'b0,
    ceo_out:    1'b0,
    ceo_oe_n:   pscc_pkg::ODRAIN_OFF,
    init_done:  1'b0,
    err:        1'b0,
    ser_out:    1'b0,
    ser_oe_n:   pscc_pkg::ODRAIN_OFF,
    ser_in:     1'b0
  };

  pscc_loader_state_type r;
  pscc_loader_state_type next_r;

  // Clears byte assembly and stream counters so that an aborted stream leaves no partial byte or count; words already pushed stay queued.
  function automatic pscc_loader_state_type stream_clear(input pscc_loader_state_type s);
    stream_clear          = s;
    stream_clear.bit_cnt  = pscc_pkg::BIT_ZERO;
    stream_clear.shift    = pscc_pkg::WORD_ZERO;
    stream_clear.word_cnt = pscc_pkg::WCNT_ZERO;
    stream_clear.check    = pscc_pkg::WORD_ZERO;
  endfunction

  logic       ck_s;
  logic       data_s;
  logic       ce_n_s;
  logic       ccf_s;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;

  pscc_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in ({config_clock, config_serial_in, chip_enable_n, config_complete_in}),
    .sync_out ({ck_s, data_s, ce_n_s, ccf_s})
  );

  // Words wait here so that a slow array writer does not lose stream data.
  pscc_fifo #(
    .WIDTH (pscc_pkg::WORD_W),
    .DEPTH (pscc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (r.push_valid),
    .in_data   (r.push_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (cfg_ready)
  );

  always_comb
  begin
    logic                 ck_rise;
    logic [7:0]           word;
    ck_rise = ck_s && !r.ck_prev;
    word    = {data_s, r.shift[7:1]};
    next_r  = r;
    next_r.ck_prev = ck_s;
    next_r.ser_in  = data_s;
    if (r.push_valid && fifo_in_ready)
      next_r.push_valid = 1'b0;
    unique case (r.state)
      pscc_pkg::PSCC_IDLE:
      begin
        next_r.ccf_oe_n = 1'b0; // R6
        if (!ce_n_s) // R12
        begin
          next_r       = stream_clear(next_r);
          next_r.state = pscc_pkg::PSCC_LOAD;
        end
      end
      pscc_pkg::PSCC_LOAD:
      begin
        // A halted clock leaves every counter where it is; no timeout exists.
        if (ce_n_s) // R12
        begin
          next_r       = stream_clear(next_r);
          next_r.state = pscc_pkg::PSCC_IDLE;
        end
        else if (ck_rise) // R1 R2
        begin
          next_r.shift   = word;
          next_r.bit_cnt = r.bit_cnt + 3'h1;
          if (r.bit_cnt == pscc_pkg::LAST_BIT)
          begin
            // A word still waiting for the FIFO is an overrun, not a stall.
            // The waiting word is kept, so the words handed on stay in stream order.
            if (r.push_valid && !fifo_in_ready)
              next_r.state = pscc_pkg::PSCC_ERROR;
            else
            begin
              next_r.check      = r.check ^ word;
              next_r.word_cnt   = r.word_cnt + 7'h01;
              next_r.push_data  = word;
              next_r.push_valid = 1'b1;
              if (r.word_cnt == pscc_pkg::STREAM_WORDS - 7'h01)
                next_r.state = ((r.check ^ word) == pscc_pkg::WORD_ZERO) ?
                               pscc_pkg::PSCC_INIT : pscc_pkg::PSCC_ERROR; // R7
            end
          end
        end
      end
      pscc_pkg::PSCC_INIT:
      begin
        next_r.ccf_oe_n = pscc_pkg::ODRAIN_OFF; // R7
        // The count waits for the released flag to be seen high on the pin.
        if (ccf_s) // R8
        begin
          next_r.init_cnt = r.init_cnt + 4'h1;
          if (r.init_cnt == pscc_pkg::INIT_CYCLES - 4'h1)
            next_r.state = pscc_pkg::PSCC_USER;
        end
      end
      pscc_pkg::PSCC_USER:
      begin
        // Nothing here looks at the flag pin or chip enable again. R9
        next_r.init_done = 1'b1; // R18
        next_r.ceo_out   = 1'b0;
        next_r.ceo_oe_n  = user_ceo_release; // R15 R17
        next_r.ser_out   = user_serial_out; // R5
        next_r.ser_oe_n  = user_serial_oe_n; // R4
      end
      pscc_pkg::PSCC_ERROR:
      begin
        next_r.ccf_oe_n = 1'b0; // R6
        next_r.err      = 1'b1;
        if (ce_n_s) // R11 R13
        begin
          next_r.state = pscc_pkg::PSCC_IDLE;
          next_r.err   = 1'b0;
        end
      end
      default:
        next_r.state = pscc_pkg::PSCC_IDLE;
    endcase
    if (next_r.state == pscc_pkg::PSCC_IDLE)
      next_r.init_cnt = pscc_pkg::INIT_ZERO;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      r <= RESET_STATE;
    else if (clk_en)
      r <= next_r;
  end

  // Configuration word outputs are registered inside the FIFO head stage.
  assign cfg_valid            = fifo_out_valid;
  assign cfg_data             = fifo_out_data;
  assign config_serial_out    = r.ser_out;
  assign config_serial_oe_n   = r.ser_oe_n;
  assign config_complete_out  = 1'b0;
  assign config_complete_oe_n = r.ccf_oe_n;
  assign chip_enable_out_n    = r.ceo_out;
  assign chip_enable_out_oe_n = r.ceo_oe_n;
  assign init_complete_flag   = r.init_done;
  assign load_error           = r.err;
  assign user_serial_in       = r.ser_in;

endmodule

`default_nettype wire

// ==== pscc_loader_sva.sv ====
// Checker for the loader's pin and word-stream behaviour.
// Assumes it is bound to pscc_loader and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pscc_loader_sva (
  // Clock and control
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // Pins and status
  input wire logic       user_serial_oe_n,
  input wire logic       user_ceo_release,
  input wire logic       config_serial_oe_n,
  input wire logic       config_complete_oe_n,
  input wire logic       chip_enable_out_n,
  input wire logic       chip_enable_out_oe_n,
  input wire logic       init_complete_flag,
  input wire logic       load_error,
  // Words
  input wire logic       cfg_valid,
  input wire logic [7:0] cfg_data,
  input wire logic       cfg_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  err_holds_low_a: assert property (load_error |-> !config_complete_oe_n)
    else $error("flag released in error");
  user_released_a: assert property (init_complete_flag |-> config_complete_oe_n)
    else $error("flag pulled low in user mode");
  user_sticky_a: assert property (init_complete_flag |=> init_complete_flag)
    else $error("user mode left");
  init_wait_a: assert property ($rose(config_complete_oe_n) |-> (!init_complete_flag) [*8])
    else $error("user mode before initialization");
  chain_low_a: assert property (!chip_enable_out_oe_n |-> init_complete_flag && !chip_enable_out_n)
    else $error("chain enable driven early");
  serial_tri_a: assert property (!init_complete_flag |-> config_serial_oe_n)
    else $error("serial pin driven in configuration");
  serial_user_a: assert property (init_complete_flag && $past(init_complete_flag)
    |-> config_serial_oe_n == $past(user_serial_oe_n))
    else $error("serial enable not following user");
  ceo_user_a: assert property (init_complete_flag && $past(init_complete_flag)
    |-> chip_enable_out_oe_n == $past(user_ceo_release))
    else $error("chain pin not following user");
  word_hold_a: assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data))
    else $error("word dropped before taken");
  cover property ($rose(init_complete_flag));
  cover property ($rose(load_error));
  cover property (cfg_valid && !cfg_ready);
endmodule
bind pscc_loader pscc_loader_sva chk_u (.clk_sys, .sys_rst, .user_serial_oe_n, .user_ceo_release,
  .config_serial_oe_n, .config_complete_oe_n, .chip_enable_out_n, .chip_enable_out_oe_n,
  .init_complete_flag, .load_error, .cfg_valid, .cfg_data, .cfg_ready);
`default_nettype wire

// ==== pscc_host.sv ====
// Host model that clocks bytes into the loader, LSB first.
// Assumes each byte is started on a rising clk_sys edge; the clock stands low between bytes.
`timescale 1ns/1ps
`default_nettype none
module pscc_host (
  // Link pins
  output logic config_clock,
  output logic config_serial_in
);
  initial
  begin
    config_clock = 1'b0;
    config_serial_in = 1'b0;
  end
  task automatic send_byte(input logic [7:0] b);
    #1;
    for (int i = 0; i < 8; i++)
    begin
      config_serial_in = b[i];
      #400 config_clock = 1'b1;
      #400 config_clock = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the loader with a byte-queue reference.
// Assumes pscc_host drives the link and the flag pin has a pull-up.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
  $display("FAIL %s exp %0h seen %0h", n, e, s); end end
module testbench;
  logic       clk_sys, sys_rst, clk_en, chip_enable_n, ext_pull, stall;
  logic       user_serial_out, user_serial_oe_n, user_ceo_release, cfg_ready;
  logic       config_clock, host_data, ser_wire, ccf_wire, ser_out, ser_oe_n;
  logic       ccf_out, ccf_oe_n, ceo_n, ceo_oe_n, init_flag, load_error, user_in, cfg_valid;
  logic [7:0] cfg_data, exp_w;
  logic [7:0] exp_q[$];
  integer     seed, n_fail, n_compared, n_words;
  assign ser_wire = (ser_oe_n === 1'b0) ? ser_out : host_data;
  assign ccf_wire = ((ccf_oe_n === 1'b0) ? ccf_out : 1'b1) && !ext_pull;
  pscc_host host_u (.config_clock(config_clock), .config_serial_in(host_data));
  pscc_loader dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .config_clock(config_clock),
    .chip_enable_n(chip_enable_n), .config_serial_in(ser_wire), .config_serial_out(ser_out),
    .config_serial_oe_n(ser_oe_n), .config_complete_in(ccf_wire), .config_complete_out(ccf_out),
    .config_complete_oe_n(ccf_oe_n), .chip_enable_out_n(ceo_n), .chip_enable_out_oe_n(ceo_oe_n),
    .init_complete_flag(init_flag), .load_error(load_error), .user_serial_out(user_serial_out),
    .user_serial_oe_n(user_serial_oe_n), .user_ceo_release(user_ceo_release),
    .user_serial_in(user_in), .cfg_valid(cfg_valid), .cfg_data(cfg_data), .cfg_ready(cfg_ready));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    #1 cfg_ready = stall ? 1'b0 : 1'($random(seed));
  end
  // Sampled mid-cycle, where valid and ready stand as the next rising edge takes them.
  always @(negedge clk_sys)
  begin
    if (sys_rst === 1'b0 && cfg_valid === 1'b1 && cfg_ready === 1'b1)
    begin
      n_words++;
      exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      `CHK("cfg_data", exp_w, cfg_data)
    end
  end
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic run_stream(input logic bad, input logic ce_off, input int n);
    logic [7:0] b;
    logic [7:0] x;
    x = 8'h00;
    chip_enable_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 chip_enable_n = ce_off;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < n; i++)
    begin
      b = (i == 63) ? (x ^ {7'h00, bad}) : 8'($random(seed));
      x = x ^ b;
      if (!ce_off)
        exp_q.push_back(b);
      @(posedge clk_sys);
      host_u.send_byte(b);
      if (i == 20)
      begin
        repeat (60) @(posedge clk_sys);
        #1;
        `CHK("flag in load", 1'b0, ccf_wire)
      end
    end
    repeat (40) @(posedge clk_sys);
    #1;
  endtask
  initial
  begin
    seed = 32'h64d66b48;
    {n_fail, n_compared, n_words} = '0;
    {sys_rst, clk_en, chip_enable_n} = 3'h7;
    {ext_pull, stall, user_serial_out, user_serial_oe_n, user_ceo_release} = 5'h03;
    repeat (5) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    run_stream(1'b0, 1'b1, 8);
    `CHK("words while disabled", 0, n_words)
    stall = 1'b1;
    run_stream(1'b0, 1'b0, 24);
    `CHK("overrun error", 1'b1, load_error)
    stall = 1'b0;
    repeat (100) @(posedge clk_sys);
    `CHK("fifo filled", 1'b1, n_words >= pscc_pkg::FIFO_DEPTH)
    exp_q.delete();
    run_stream(1'b1, 1'b0, 64);
    `CHK("check error", 1'b1, load_error)
    `CHK("flag after error", 1'b0, ccf_wire)
    run_stream(1'b0, 1'b0, 10);
    `CHK("partial error", 1'b0, load_error)
    `CHK("flag partial", 1'b0, ccf_wire)
    run_stream(1'b0, 1'b0, 64);
    `CHK("good error", 1'b0, load_error)
    `CHK("flag released", 1'b1, ccf_wire)
    `CHK("user mode", 1'b1, init_flag)
    `CHK("words left", 0, exp_q.size())
    `CHK("serial tristate", 1'b1, ser_oe_n)
    `CHK("serial in", host_data, user_in)
    for (int r = 0; r < 2; r++)
    begin
      user_ceo_release = r[0];
      user_serial_out = 1'($random(seed));
      user_serial_oe_n = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      `CHK("chain enable", user_ceo_release, ceo_oe_n)
      `CHK("user serial", user_serial_out, user_in)
    end
    {ext_pull, chip_enable_n} = 2'h3;
    repeat (30) @(posedge clk_sys);
    #1;
    `CHK("user after pull", 1'b1, init_flag)
    `CHK("chain after pull", 1'b0, ceo_n)
    finish_test();
  end
  initial
  begin
    #5000000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
